/* File: pkg/sar_pkg.sv */
package sar_pkg;
  // ---------------------------------------------------------------
  // sizes and counts
  // ---------------------------------------------------------------
  localparam int RES_BITS = 16;
  localparam int LEAD_FALLS = 5;      // falling edge that enables the pin
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LEAD = 5'h05;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h15; // lead + 16 bits
  localparam logic [RES_BITS-1:0] CODE_ZERO = 16'h0000;
  localparam logic [RES_BITS-1:0] CODE_MID = 16'h8000;
  localparam logic [RES_BITS-1:0] CODE_FULL = 16'hffff;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SAR_IDLE = 4'h1,
    SAR_LEAD = 4'h2,
    SAR_SHIFT = 4'h4,
    SAR_DONE = 4'h8
  } sar_state_e;

  // serial data pin as data and enable
  typedef struct packed {
    logic data;
    logic oe_n;
  } sar_pin_s;
endpackage : sar_pkg

/* File: design/sar_readout.sv */
`timescale 1ns/100ps
module sar_readout
  import sar_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // serial link pins
  input wire logic sel_n_i,
  input wire logic host_shift_clock_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  // converter core side
  input wire logic [RES_BITS-1:0] sample_i,
  input wire logic under_i,
  input wire logic over_i,
  output logic convert_o,
  output logic power_down_o
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic sel_s1_r, sel_s2_r, sel_s3_r;
  logic clk_s1_r, clk_s2_r, clk_s3_r;
  logic sel_s1_nxt, clk_s1_nxt;

  // plain capture, second stage alone reads the first
  always_comb
  begin
    sel_s1_nxt = sel_n_i;
    clk_s1_nxt = host_shift_clock_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_s3_r <= 1'b1;
      // host clock idles high, so no false fall after reset
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      clk_s3_r <= 1'b1;
    end
    else
    begin
      sel_s1_r <= sel_s1_nxt;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
      clk_s1_r <= clk_s1_nxt;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
    end
  end

  logic sel_fall, sclk_fall;
  assign sel_fall = sel_s3_r & ~sel_s2_r;
  assign sclk_fall = clk_s3_r & ~clk_s2_r;

  // ---------------------------------------------------------------
  // conversion and shift sequencer
  // ---------------------------------------------------------------
  sar_state_e state_r, state_nxt;
  logic [CNT_W-1:0] falls_r, falls_nxt;
  logic [RES_BITS-1:0] shreg_r, shreg_nxt;
  logic sdo_r, sdo_nxt;
  logic oe_n_r, oe_n_nxt;
  logic conv_r, conv_nxt;
  logic pd_r, pd_nxt;
  logic [RES_BITS-1:0] code;

  // clamp out-of-range inputs to the end codes
  always_comb
  begin
    if (over_i)
      code = CODE_FULL;
    else if (under_i)
      code = CODE_ZERO;
    else
      code = sample_i;
  end

  always_comb
  begin
    state_nxt = state_r;
    falls_nxt = falls_r;
    shreg_nxt = shreg_r;
    sdo_nxt = sdo_r;
    oe_n_nxt = oe_n_r;
    conv_nxt = 1'b0;
    pd_nxt = pd_r;
    // select high always aborts and floats the pin
    if (sel_s2_r)
    begin
      state_nxt = SAR_IDLE;
      oe_n_nxt = 1'b1;
      sdo_nxt = 1'b0;
      falls_nxt = CNT_ZERO;
      pd_nxt = 1'b1;
    end
    else
    begin
      unique case (state_r)
        SAR_IDLE:
        begin
          if (sel_fall)
          begin
            // the core result is latched at once, so no pipeline lag
            state_nxt = SAR_LEAD;
            conv_nxt = 1'b1;
            pd_nxt = 1'b0;
            shreg_nxt = code;
            falls_nxt = CNT_ZERO;
          end
        end
        SAR_LEAD:
        begin
          pd_nxt = 1'b1;
          if (sclk_fall)
          begin
            falls_nxt = falls_r + CNT_ONE;
            if (falls_r + CNT_ONE == CNT_LEAD)
            begin
              oe_n_nxt = 1'b0;
              sdo_nxt = 1'b0;
              state_nxt = SAR_SHIFT;
            end
          end
        end
        SAR_SHIFT:
        begin
          // bit changes only on a fall, so it spans rise and fall
          if (sclk_fall)
          begin
            falls_nxt = falls_r + CNT_ONE;
            sdo_nxt = shreg_r[RES_BITS-1];
            shreg_nxt = {shreg_r[RES_BITS-2:0], 1'b0};
            if (falls_r + CNT_ONE == CNT_LAST)
              state_nxt = SAR_DONE;
          end
        end
        SAR_DONE:
        begin
          // extra clocks after the lsb shift out zeros
          if (sclk_fall)
            sdo_nxt = 1'b0;
        end
        default:
          state_nxt = SAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= SAR_IDLE;
      falls_r <= CNT_ZERO;
      shreg_r <= CODE_ZERO;
      sdo_r <= 1'b0;
      oe_n_r <= 1'b1;
      conv_r <= 1'b0;
      pd_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      falls_r <= falls_nxt;
      shreg_r <= shreg_nxt;
      sdo_r <= sdo_nxt;
      oe_n_r <= oe_n_nxt;
      conv_r <= conv_nxt;
      pd_r <= pd_nxt;
    end
  end

  sar_pin_s pin;
  assign pin = '{data: sdo_r, oe_n: oe_n_r};
  assign sdo_o = pin.data;
  assign sdo_oe_n_o = pin.oe_n;
  assign convert_o = conv_r;
  assign power_down_o = pd_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_start;
    @(posedge sys_clk_i) disable iff (rst_i)
    (sel_fall && state_r == SAR_IDLE) |=> convert_o && state_r == SAR_LEAD;
  endproperty
  a_start: assert property (p_start) else $error("no start");

  property p_lead;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == SAR_LEAD && sclk_fall && !sel_s2_r
      && falls_r == CNT_LEAD - CNT_ONE)
      |=> !sdo_oe_n_o && !sdo_o;
  endproperty
  a_lead: assert property (p_lead) else $error("lead bit wrong");

  property p_float_lead;
    @(posedge sys_clk_i) disable iff (rst_i)
    state_r == SAR_LEAD |-> sdo_oe_n_o;
  endproperty
  a_float_lead: assert property (p_float_lead) else $error("early drive");

  property p_msb;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == SAR_SHIFT && sclk_fall && !sel_s2_r)
      |=> sdo_o == $past(shreg_r[RES_BITS-1]);
  endproperty
  a_msb: assert property (p_msb) else $error("bit order wrong");

  property p_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!sclk_fall && !sel_s2_r && state_r != SAR_IDLE) |=> $stable(sdo_o);
  endproperty
  a_hold: assert property (p_hold) else $error("bit moved");

  property p_pd;
    @(posedge sys_clk_i) disable iff (rst_i)
    convert_o |=> power_down_o;
  endproperty
  a_pd: assert property (p_pd) else $error("no power down");

  property p_clamp;
    @(posedge sys_clk_i) disable iff (rst_i)
    (sel_fall && state_r == SAR_IDLE && over_i) |=> shreg_r == CODE_FULL;
  endproperty
  a_clamp: assert property (p_clamp) else $error("no clamp");

  property p_word;
    @(posedge sys_clk_i) disable iff (rst_i)
    (sel_fall && state_r == SAR_IDLE && !over_i && !under_i)
      |=> shreg_r == $past(sample_i);
  endproperty
  a_word: assert property (p_word) else $error("stale word");

  property p_release;
    @(posedge sys_clk_i) disable iff (rst_i)
    sel_s2_r |=> sdo_oe_n_o;
  endproperty
  a_release: assert property (p_release) else $error("pin driven");

  c_start: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    convert_o);
  c_drive: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(sdo_oe_n_o));
  c_done: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == SAR_DONE);
endmodule : sar_readout

/* File: sim/sar_host.sv */
`timescale 1ns/100ps
// ---------------------------------------------
// host serial port model
// ---------------------------------------------
module sar_host
(
  // frame control
  input wire logic go_i,
  input wire logic [4:0] falls_i,
  output logic done_o,
  output logic [16:0] rise_o,
  output logic [16:0] fall_o,
  // link pins
  output logic sel_n_o,
  output logic sclk_o,
  input wire logic sdo_i,
  input wire logic oe_n_i
);
  logic last;
  logic line;
  // a released pin shows the inverse of its last driven value
  assign line = oe_n_i ? ~last : sdo_i;
  always @(sdo_i or oe_n_i)
    if (!oe_n_i) last = sdo_i;
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o = 1'b1;
    done_o = 1'b0;
    last = 1'b0;
    rise_o = 17'h00000;
    fall_o = 17'h00000;
  end
  // one frame; the clock stands high between frames
  always @(posedge go_i)
  begin
    done_o = 1'b0;
    sel_n_o = 1'b0;
    #200;
    for (int k = 1; k <= falls_i; k++)
    begin
      if (k >= 6) fall_o = {fall_o[15:0], line};
      sclk_o = 1'b0;
      #80;
      if (k >= 5 && k < 22) rise_o = {rise_o[15:0], line};
      sclk_o = 1'b1;
      #80;
    end
    sel_n_o = 1'b1;
    #100;
    done_o = 1'b1;
  end
endmodule : sar_host

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb
  import sar_pkg::*;
;
  logic sys_clk_i, rst_i, sel_n, sclk, sdo, oe_n, under, over;
  logic convert, pdown, go, done;
  logic [15:0] sample;
  logic [4:0] falls;
  logic [16:0] rise_w, fall_w, exp_w;
  logic [16:0] exp_q[$];
  logic [31:0] r;
  int fails, n_checks, conv_n, n_fr;

  sar_readout dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sel_n_i(sel_n),
    .host_shift_clock_i(sclk), .sdo_o(sdo), .sdo_oe_n_o(oe_n),
    .sample_i(sample), .under_i(under), .over_i(over),
    .convert_o(convert), .power_down_o(pdown));
  sar_host host (.go_i(go), .falls_i(falls), .done_o(done),
    .rise_o(rise_w), .fall_o(fall_w), .sel_n_o(sel_n), .sclk_o(sclk),
    .sdo_i(sdo), .oe_n_i(oe_n));

  // -------------------------------------------
  // compare and report
  // -------------------------------------------
  task check_word(input string what, input logic [16:0] e,
                  input logic [16:0] g);
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", what, e, g);
      fails++;
    end
    n_checks++;
  endtask : check_word
  task check_bit(input string what, input logic e, input logic g);
    check_word(what, {16'h0000, e}, {16'h0000, g});
  endtask : check_bit
  task results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // one frame; the core value changes after start to expose late reads
  task frame(input logic u, input logic o, input logic [4:0] n,
             input logic [15:0] s);
    @(negedge sys_clk_i);
    sample = s;
    under = u;
    over = o;
    falls = n;
    go = 1'b1;
    n_fr++;
    if (n == 5'h16)
      exp_q.push_back({1'b0, o ? CODE_FULL : (u ? CODE_ZERO : s)});
    @(negedge sys_clk_i);
    go = 1'b0;
    for (int i = 0; i <= 1000; i++)
    begin
      if (i == 1000)
      begin
        fails++;
        results();
      end
      @(negedge sys_clk_i);
      // core value moves only once the start has latched it
      if (convert === 1'b1) sample = ~s;
      if (done === 1'b1) break;
    end
    check_bit("oe_n idle", 1'b1, oe_n);
    check_bit("power down idle", 1'b1, pdown);
  endtask : frame

  // -------------------------------------------
  // clock, monitors, sequence
  // -------------------------------------------
  initial sys_clk_i = 1'b0;
  always #5 sys_clk_i = ~sys_clk_i;
  // count starts; power is up only in the start cycle
  always @(negedge sys_clk_i)
    if (convert === 1'b1)
    begin
      conv_n++;
      check_bit("power down at start", 1'b0, pdown);
    end
  // oldest expected word against both capture edges
  always @(posedge done)
    if (exp_q.size() > 0)
    begin
      exp_w = exp_q.pop_front();
      check_word("rise word", exp_w, rise_w);
      check_word("fall word", exp_w, fall_w);
    end
  initial
  begin
    rst_i = 1'b1;
    go = 1'b0;
    falls = 5'h16;
    sample = 16'h0000;
    under = 1'b0;
    over = 1'b0;
    void'($urandom(49246));
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    frame(1'b0, 1'b0, 5'h16, CODE_MID);
    frame(1'b1, 1'b0, 5'h16, 16'h1234);
    frame(1'b0, 1'b1, 5'h16, 16'h0001);
    frame(1'b1, 1'b1, 5'h16, 16'h7fff);
    // abort mid-word, then a clean frame must follow
    frame(1'b0, 1'b0, 5'h0a, 16'haaaa);
    for (int j = 0; j < 4; j++)
    begin
      r = $urandom;
      frame(1'b0, 1'b0, 5'h16, r[15:0]);
    end
    repeat (20) @(negedge sys_clk_i);
    check_word("starts", n_fr[16:0], conv_n[16:0]);
    check_word("words left", 17'h00000, 17'(exp_q.size()));
    results();
  end
endmodule : tb
